// [core/tif_map.vh]
// Register offsets, field positions, reset values and response codes for the
// timer interrupt flag block. Definitions only; included by the main file.
`ifndef TIF_MAP_VH
`define TIF_MAP_VH
`define TIF_ADDR_W 4
`define TIF_OFS_CONTROL 4'h0
`define TIF_OFS_CLEAR 4'h4
`define TIF_OFS_STATUS 4'h8
`define TIF_OFS_MASK 4'hc
`define TIF_PND_LSB 0
`define TIF_IEN_LSB 4
`define TIF_CONTROL_RST 8'h00
`define TIF_EN_RST 4'h0
`define TIF_IRQ_RST 4'h0
`define TIF_MODE_W 2
`define TIF_RESP_OKAY 2'b00
`define TIF_RESP_SLVERR 2'b10
`endif

// [core/tif_event_select.v]
// Event selection for the four interrupt sources, one flop stage deep.
// Assumes the timer core gives one-cycle event pulses synchronous to aclk.
`timescale 1ns/1ps
module tif_event_select (
  input wire aclk,
  input wire aresetn,
  input wire [1:0] timer_mode,
  input wire [3:0] ev_mode1,
  input wire [3:0] ev_mode2,
  input wire [3:0] ev_mode3,
  input wire [3:0] ev_mode4,
  output reg [3:0] src_event_r
);
  // The mode picks which event group feeds the flags; registered for timing.
  always @(posedge aclk) begin
    if (!aresetn) begin
      src_event_r <= 4'h0;
    end else begin
      case (timer_mode)
        2'h0: src_event_r <= ev_mode1;
        2'h1: src_event_r <= ev_mode2;
        2'h2: src_event_r <= ev_mode3;
        default: src_event_r <= ev_mode4;
      endcase
    end
  end
endmodule // tif_event_select

// [core/tif_flags.v]
// Interrupt enable and pending flags of a multi-function timer, on AXI4-Lite.
// Assumes one clock aclk, synchronous active-low reset, event pulses on aclk.
//
// How it works
// - byte control register, enables and pendings.
// - reset clears all enables and pendings.
// - timer mode selects event per flag.
// - event or software one sets flag.
// - writing zero to pending changes nothing.
// - pending reads one once triggered.
// - enabled sources request interrupts, others suppressed.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "tif_map.vh"
module tif_flags #(
  parameter NSRC = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [1:0] timer_mode,
  input wire [3:0] ev_mode1,
  input wire [3:0] ev_mode2,
  input wire [3:0] ev_mode3,
  input wire [3:0] ev_mode4,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg timer_irq_r,
  output reg irq_r
);
  // ****************************************************************
  // Register map, one aligned word each
  // ****************************************************************
  // 0x0 control: bits 7:4 enables D..A, bits 3:0 pending D..A.
  // 0x4 clear: a one clears the matching pending flag; it reads as zero.
  // 0x8 status: sticky record of enabled events; a read of it clears it.
  // 0xc mask: a one lets the matching status bit drive irq_r.
  // Other offsets answer SLVERR and leave every register alone.
  // Writes with byte lane 0 switched off change nothing.
  // Only one write and one read are ever in flight, so nothing is queued.

  // ****************************************************************
  // State
  // ****************************************************************
  reg [3:0] enable_r;
  reg [3:0] pending_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_mask_r;
  reg [3:0] awaddr_r;
  reg have_aw_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg have_w_r;
  wire [3:0] src_event;
  wire wr_go;
  wire rd_go;
  reg [3:0] pending_nxt;
  reg [3:0] enable_nxt;
  reg [3:0] irq_stat_nxt;
  reg [3:0] irq_mask_nxt;
  reg [31:0] rdata_nxt;
  reg [1:0] rresp_nxt;
  reg [1:0] bresp_nxt;
  wire aw_take;
  wire w_take;
  wire r_done;
  wire b_done;
  reg awready_nxt;
  reg wready_nxt;
  reg bvalid_nxt;
  reg arready_nxt;
  reg rvalid_nxt;
  reg timer_irq_nxt;
  reg irq_nxt;
  wire wr_control;
  wire wr_clear;
  wire wr_mask;
  wire rd_status;

  // Known offsets answer OKAY, anything else SLVERR.
  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `TIF_OFS_CONTROL) || (a == `TIF_OFS_CLEAR) ||
               (a == `TIF_OFS_STATUS) || (a == `TIF_OFS_MASK);
    end
  endfunction

  // Write strobe lane 0 and the offset together decide a register hit.
  function wr_hit;
    input [3:0] a;
    input [3:0] ofs;
    input lane0;
    begin
      wr_hit = lane0 && (a == ofs);
    end
  endfunction

  tif_event_select u_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .timer_mode(timer_mode),
    .ev_mode1(ev_mode1),
    .ev_mode2(ev_mode2),
    .ev_mode3(ev_mode3),
    .ev_mode4(ev_mode4),
    .src_event_r(src_event)
  );

  // ****************************************************************
  // AXI4-Lite write channel capture
  // ****************************************************************
  // Address and data are latched independently so either may come first.
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign b_done = s_axi_bvalid && s_axi_bready;
  assign wr_go = have_aw_r && have_w_r && !s_axi_bvalid;

  // A channel is ready only while its holding register is empty and no
  // response is left waiting; one write in flight needs no queue.
  always @* begin
    awready_nxt = !have_aw_r && !aw_take && (!s_axi_bvalid || b_done);
    wready_nxt = !have_w_r && !w_take && (!s_axi_bvalid || b_done);
    bvalid_nxt = s_axi_bvalid;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
    end else if (b_done) begin
      bvalid_nxt = 1'b0;
    end
  end

  // Holding registers for one write; emptied when the write is applied.
  always @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_take) begin
        have_aw_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        have_aw_r <= 1'b0;
      end
      if (w_take) begin
        have_w_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        have_w_r <= 1'b0;
      end
    end
  end

  // Handshake outputs and the write response, each straight from a flop.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TIF_RESP_OKAY;
    end else begin
      s_axi_awready <= awready_nxt;
      s_axi_wready <= wready_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (wr_go) begin
        s_axi_bresp <= bresp_nxt;
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign r_done = s_axi_rvalid && s_axi_rready;

  // Read data mux; a status read is also the clear of that register.
  always @* begin
    rdata_nxt = 32'h0;
    rresp_nxt = `TIF_RESP_OKAY;
    case (s_axi_araddr)
      `TIF_OFS_CONTROL: rdata_nxt[7:0] = {enable_r, pending_r};
      `TIF_OFS_STATUS: rdata_nxt[3:0] = irq_stat_r;
      `TIF_OFS_MASK: rdata_nxt[3:0] = irq_mask_r;
      `TIF_OFS_CLEAR: rdata_nxt = 32'h0;
      default: rresp_nxt = `TIF_RESP_SLVERR;
    endcase
  end

  // The address is refused while read data wait, so one read is in flight.
  always @* begin
    arready_nxt = !s_axi_rvalid && !rd_go;
    rvalid_nxt = s_axi_rvalid;
    if (rd_go) begin
      rvalid_nxt = 1'b1;
    end else if (r_done) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Read data and response are captured with the address handshake.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TIF_RESP_OKAY;
    end else begin
      s_axi_arready <= arready_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (rd_go) begin
        s_axi_rdata <= rdata_nxt;
        s_axi_rresp <= rresp_nxt;
      end
    end
  end

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // Only byte lane 0 holds register bits; the other lanes are ignored.
  assign wr_control = wr_go && wr_hit(awaddr_r, `TIF_OFS_CONTROL, wstrb_r[0]);
  assign wr_clear = wr_go && wr_hit(awaddr_r, `TIF_OFS_CLEAR, wstrb_r[0]);
  assign wr_mask = wr_go && wr_hit(awaddr_r, `TIF_OFS_MASK, wstrb_r[0]);
  // A status read is also its clear, so it keys on the address handshake.
  assign rd_status = rd_go && (s_axi_araddr == `TIF_OFS_STATUS);

  // ****************************************************************
  // Flag update
  // ****************************************************************
  // Hardware events win over a clear in the same cycle, so none is lost.
  always @* begin
    enable_nxt = enable_r;
    pending_nxt = pending_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    bresp_nxt = mapped(awaddr_r) ? `TIF_RESP_OKAY : `TIF_RESP_SLVERR;
    if (rd_status) begin
      irq_stat_nxt = 4'h0;
    end
    if (wr_control) begin
      enable_nxt = wdata_r[`TIF_IEN_LSB +: 4];
      pending_nxt = pending_r | wdata_r[`TIF_PND_LSB +: 4];
    end
    if (wr_clear) begin
      pending_nxt = pending_r & ~wdata_r[3:0];
    end
    if (wr_mask) begin
      irq_mask_nxt = wdata_r[3:0];
    end
    pending_nxt = pending_nxt | src_event;
    irq_stat_nxt = irq_stat_nxt | (src_event & enable_r);
  end

  // Register state, all cleared together by reset.
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= `TIF_EN_RST;
      pending_r <= `TIF_IRQ_RST;
      irq_stat_r <= `TIF_IRQ_RST;
      irq_mask_r <= `TIF_IRQ_RST;
    end else begin
      enable_r <= enable_nxt;
      pending_r <= pending_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Levels come from next state, so they change on the same edge as the
  // flags and a user sees no extra cycle between a flag and its request.
  always @* begin
    timer_irq_nxt = |(pending_nxt & enable_nxt);
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  // Both interrupt outputs come straight from flops.
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      timer_irq_r <= timer_irq_nxt;
      irq_r <= irq_nxt;
    end
  end
endmodule // tif_flags

// [dv/tif_flags_monitor.sv]
// Checker for tif_flags: bus handshakes, read data and reset levels.
// Assumes it is bound to tif_flags, one clock and active-low sync reset.
`timescale 1ns/1ps
module tif_mon (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire timer_irq_r,
  input wire irq_r
);
  // All checks share the bus clock and are idle during reset.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_clear: assert property (!$past(aresetn) |-> !timer_irq_r && !irq_r)
    else $error("interrupt high after reset");
  // The main traffic kinds must each be seen once.
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(timer_irq_r));
  c_mask_irq: cover property ($rose(irq_r));
endmodule // tif_mon
bind tif_flags tif_mon i_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .timer_irq_r(timer_irq_r),
  .irq_r(irq_r));

// [dv/tb_top.sv]
// Self-checking bench for tif_flags over AXI4-Lite.
// Assumes every request is answered within 50 clock cycles.
`timescale 1ns/1ps
`include "tif_map.vh"
module tb_top;
  reg aclk = 0;
  reg aresetn = 0;
  reg [1:0] mode = 0;
  reg [3:0] ev [0:3];
  reg [3:0] awaddr = 0;
  reg [3:0] araddr = 0;
  reg [31:0] wdata = 0;
  reg awvalid = 0;
  reg wvalid = 0;
  reg bready = 0;
  reg arvalid = 0;
  reg rready = 0;
  wire awready, wready, bvalid, arready, rvalid, tirq, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [33:0] q [$];
  reg [33:0] wq [$];
  reg [3:0] wstrb = 4'hf;
  reg [3:0] v;
  integer bad_count = 0, n_tests = 0, seed = 32'h221b, i, k;
  always #25 aclk = ~aclk;
  tif_flags i_dut (.aclk(aclk), .aresetn(aresetn), .timer_mode(mode), .ev_mode1(ev[0]),
    .ev_mode2(ev[1]), .ev_mode3(ev[2]), .ev_mode4(ev[3]), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_irq_r(tirq), .irq_r(irq));
  task conclude;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input [33:0] got, input [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that ran out is a fault and closes the run.
  task tmo(input integer n);
    if (n >= 50) begin
      bad_count++;
      conclude;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    integer n;
    wq.push_back((a[1:0] == 2'b00) ? 34'h0 : {32'h0, `TIF_RESP_SLVERR});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 0;
      if (wready && wvalid) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    tmo(n);
  endtask
  task rd(input [3:0] a, input [33:0] e);
    integer n;
    q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    tmo(n);
  endtask
  // One cycle of random events on all groups; v keeps the selected group's.
  task fire(input [1:0] m);
    @(posedge aclk);
    mode <= m;
    for (k = 0; k < 4; k++) ev[k] <= 4'($random(seed));
    @(posedge aclk);
    v = ev[m];
    for (k = 0; k < 4; k++) ev[k] <= 0;
    repeat (5) @(posedge aclk);
  endtask
  // Results are matched in order against the notes of the read and write tasks.
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, q.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, wq.pop_front());
  end
  initial begin
    for (k = 0; k < 4; k++) ev[k] = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`TIF_OFS_CONTROL, 34'h0);
    for (i = 0; i < 4; i++) begin
      fire(i[1:0]);
      rd(`TIF_OFS_CONTROL, {30'h0, v});
      chk({33'h0, tirq}, 34'h0);
      wr(`TIF_OFS_CLEAR, {4'h0, v});
      rd(`TIF_OFS_CONTROL, 34'h0);
    end
    wr(`TIF_OFS_CONTROL, 8'hf5);
    wr(`TIF_OFS_CONTROL, 8'hf0);
    rd(`TIF_OFS_CONTROL, 34'hf5);
    chk({33'h0, tirq}, 34'h1);
    wr(`TIF_OFS_CLEAR, 8'h0f);
    rd(`TIF_OFS_CONTROL, 34'hf0);
    fire(2'h0);
    chk({33'h0, irq}, 34'h0);
    wr(`TIF_OFS_MASK, 8'h0f);
    rd(`TIF_OFS_MASK, 34'h0f);
    wstrb <= 4'h0;
    wr(`TIF_OFS_MASK, 8'h00);
    wstrb <= 4'hf;
    rd(`TIF_OFS_MASK, 34'h0f);
    chk({33'h0, irq}, {33'h0, |v});
    rd(`TIF_OFS_STATUS, {30'h0, v});
    rd(`TIF_OFS_STATUS, 34'h0);
    chk({33'h0, irq}, 34'h0);
    rd(4'h2, {2'b10, 32'h0});
    wr(4'h2, 8'hff);
    rd(`TIF_OFS_MASK, 34'h0f);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`TIF_OFS_CONTROL, 34'h0);
    repeat (2) @(posedge aclk);
    conclude;
  end
endmodule // tb_top
